// File: include/decode_pkg.sv
// package: constants, types and register map of the instruction decoder
package decode_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam int FLAG_N = 5;

  // alu status flag positions
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_DIGIT = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_OVERFLOW = 3;
  localparam int FLAG_NEGATIVE = 4;

  // field positions inside the instruction word
  localparam int DEST_BIT = 9;
  localparam int ACCESS_BIT = 8;
  localparam int FAST_BIT = 8;
  localparam int BIT_IDX_LSB = 9;

  // opcode nibbles used for format classification
  localparam logic [3:0] TAG_SECOND = 4'hf;
  localparam logic [3:0] OP_MISC = 4'h0;
  localparam logic [3:0] OP_BYTE_LO = 4'h1;
  localparam logic [3:0] OP_BYTE_HI = 4'h6;
  localparam logic [3:0] OP_BIT_LO = 4'h7;
  localparam logic [3:0] OP_BIT_HI = 4'hb;
  localparam logic [3:0] OP_MOVE = 4'hc;
  localparam logic [3:0] OP_REL = 4'hd;
  localparam logic [3:0] OP_CTL = 4'he;
  localparam logic [3:0] SUB_JUMP = 4'hf;
  localparam logic [2:0] SUB_CALL = 3'h6;

  // banks reached through the access window
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

  // apb register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_BANK = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_LAST_WORD = 12'h00c;
  localparam logic [11:0] OFS_ORPHANS = 12'h010;
  localparam int CTRL_ENABLE_BIT = 0;

  // values after reset
  localparam logic CTRL_RST = 1'b1;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [15:0] ORPHAN_RST = 16'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;

  typedef enum logic [3:0] {
    fmt_nop, fmt_byte, fmt_bit, fmt_literal, fmt_move,
    fmt_jump, fmt_call, fmt_rel_branch, fmt_cond_branch, fmt_other
  } fmt_e;

  typedef enum logic {st_first, st_second} state_e;

  typedef struct packed {
    fmt_e fmt;
    logic write_working;
    logic write_file;
    logic bank_access;
    logic [11:0] file_addr;
    logic [2:0] bit_index;
    logic [7:0] literal;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic [19:0] target;
    logic fast;
    logic [10:0] offset;
  } decode_s;
endpackage : decode_pkg

// File: rtl/operand_address.sv
// operand address former: access window or bank select register
`timescale 1ns/1ps
`default_nettype none
module operand_address #(
  parameter logic [7:0] SPLIT = 8'h80
) (
  input wire logic access_sel_in,
  input wire logic [7:0] file_byte_in,
  input wire logic [3:0] bank_in,
  output logic [11:0] addr_out
);
  // low window half maps to the bottom bank, upper half to the top bank
  wire logic [3:0] window_bank;
  assign window_bank = (file_byte_in < SPLIT) ? decode_pkg::ACCESS_LOW_BANK
                                              : decode_pkg::ACCESS_HIGH_BANK;
  assign addr_out = {access_sel_in ? bank_in : window_bank, file_byte_in};
endmodule : operand_address
`default_nettype wire

// File: rtl/status_flag_bit.sv
// one alu status flag with execute and software update paths
`timescale 1ns/1ps
`default_nettype none
module status_flag_bit #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic hw_we_in,
  input wire logic hw_val_in,
  input wire logic sw_we_in,
  input wire logic sw_val_in,
  output logic flag_out
);
  logic flag_q;
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
      flag_q <= RST_VAL;
    else if (hw_we_in)
      flag_q <= hw_val_in;
    else if (sw_we_in)
      flag_q <= sw_val_in;
  end
  assign flag_out = flag_q;
endmodule : status_flag_bit
`default_nettype wire

// File: rtl/instruction_format_decoder.sv
// instruction format decoder with apb register slave
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module instruction_format_decoder #(
  parameter logic [7:0] ACCESS_SPLIT = 8'h80
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [11:0] paddr_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic fetch_valid_in,
  input wire logic [15:0] fetch_word_in,
  input wire logic [4:0] flag_we_in,
  input wire logic [4:0] flag_val_in,
  output logic dec_valid_out,
  output decode_pkg::decode_s decoded_out,
  output logic [4:0] status_flags_out
);
  decode_pkg::state_e state_q;
  decode_pkg::fmt_e pend_fmt_q;
  decode_pkg::fmt_e first_fmt;
  decode_pkg::fmt_e out_fmt;
  decode_pkg::decode_s dec_d;
  decode_pkg::decode_s decoded_q;
  logic [15:0] pend_q;
  logic [15:0] last_word_q;
  logic [15:0] orphan_q;
  logic [3:0] bank_q;
  logic enable_q;
  logic dec_valid_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [4:0] flags;
  logic [11:0] formed_addr;

  // opcode classification of a word arriving as first word
  wire logic [3:0] top_nib;
  wire logic [3:0] sub_nib;
  wire logic is_second;
  wire logic is_move;
  wire logic is_bit;
  wire logic is_rel;
  wire logic is_call;
  wire logic is_jump;
  wire logic is_cond;
  wire logic is_lit;
  wire logic is_byte;
  wire logic needs_second;
  assign top_nib = fetch_word_in[15:12];
  assign sub_nib = fetch_word_in[11:8];
  assign is_second = top_nib == decode_pkg::TAG_SECOND;
  assign is_move = top_nib == decode_pkg::OP_MOVE;
  assign is_bit = top_nib >= decode_pkg::OP_BIT_LO &&
                  top_nib <= decode_pkg::OP_BIT_HI;
  assign is_rel = top_nib == decode_pkg::OP_REL;
  assign is_call = top_nib == decode_pkg::OP_CTL &&
                   sub_nib[3:1] == decode_pkg::SUB_CALL;
  assign is_jump = top_nib == decode_pkg::OP_CTL &&
                   sub_nib == decode_pkg::SUB_JUMP;
  assign is_cond = top_nib == decode_pkg::OP_CTL && !sub_nib[3];
  assign is_lit = top_nib == decode_pkg::OP_MISC && sub_nib[3];
  assign is_byte = (top_nib >= decode_pkg::OP_BYTE_LO &&
                    top_nib <= decode_pkg::OP_BYTE_HI) ||
                   (top_nib == decode_pkg::OP_MISC && !sub_nib[3] &&
                    sub_nib != 4'h0);
  assign needs_second = is_move | is_jump | is_call;

  assign first_fmt = is_second ? decode_pkg::fmt_nop :
                     is_move ? decode_pkg::fmt_move :
                     is_bit ? decode_pkg::fmt_bit :
                     is_rel ? decode_pkg::fmt_rel_branch :
                     is_call ? decode_pkg::fmt_call :
                     is_jump ? decode_pkg::fmt_jump :
                     is_cond ? decode_pkg::fmt_cond_branch :
                     is_lit ? decode_pkg::fmt_literal :
                     is_byte ? decode_pkg::fmt_byte :
                     decode_pkg::fmt_other;

  // fetch handshake and two-word sequencing terms
  wire logic take;
  wire logic in_second;
  wire logic second_bad;
  wire logic emit;
  wire logic orphan;
  wire logic [15:0] first_w;
  assign take = fetch_valid_in & enable_q;
  assign in_second = state_q == decode_pkg::st_second;
  // a pair whose second word lacks the tag is voided, not executed
  assign second_bad = in_second && !is_second;
  assign emit = take & (in_second | ~needs_second);
  assign orphan = take & ~in_second & is_second;
  assign first_w = in_second ? pend_q : fetch_word_in;
  assign out_fmt = !in_second ? first_fmt :
                   second_bad ? decode_pkg::fmt_nop : pend_fmt_q;

  operand_address #(
    .SPLIT(ACCESS_SPLIT)
  ) u_operand_address (
    .access_sel_in(first_w[decode_pkg::ACCESS_BIT]),
    .file_byte_in(first_w[7:0]),
    .bank_in(bank_q),
    .addr_out(formed_addr)
  );

  // field extraction; fields foreign to the format read as zero
  always_comb
  begin
    dec_d = '0;
    dec_d.fmt = out_fmt;
    if (out_fmt == decode_pkg::fmt_byte ||
        out_fmt == decode_pkg::fmt_bit)
    begin
      dec_d.bank_access = first_w[decode_pkg::ACCESS_BIT];
      dec_d.file_addr = formed_addr;
    end
    if (out_fmt == decode_pkg::fmt_byte)
    begin
      dec_d.write_file = first_w[decode_pkg::DEST_BIT];
      dec_d.write_working = !first_w[decode_pkg::DEST_BIT];
    end
    if (out_fmt == decode_pkg::fmt_bit)
      dec_d.bit_index = first_w[decode_pkg::BIT_IDX_LSB +: 3];
    if (out_fmt == decode_pkg::fmt_literal)
      dec_d.literal = first_w[7:0];
    if (out_fmt == decode_pkg::fmt_move)
    begin
      dec_d.src_addr = first_w[11:0];
      dec_d.dst_addr = fetch_word_in[11:0];
    end
    if (out_fmt == decode_pkg::fmt_jump || out_fmt == decode_pkg::fmt_call)
      dec_d.target = {fetch_word_in[11:0], first_w[7:0]};
    if (out_fmt == decode_pkg::fmt_call)
      dec_d.fast = first_w[decode_pkg::FAST_BIT];
    if (out_fmt == decode_pkg::fmt_rel_branch)
      dec_d.offset = first_w[10:0];
    if (out_fmt == decode_pkg::fmt_cond_branch)
      dec_d.offset = {{3{first_w[7]}}, first_w[7:0]};
  end

  // pair sequencer: holds the first word until its partner arrives
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= decode_pkg::st_first;
      pend_q <= decode_pkg::WORD_RST;
      pend_fmt_q <= decode_pkg::fmt_nop;
    end
    else if (take)
    begin
      unique case (state_q)
        decode_pkg::st_first:
        begin
          if (needs_second)
          begin
            state_q <= decode_pkg::st_second;
            pend_q <= fetch_word_in;
            pend_fmt_q <= first_fmt;
          end
        end
        decode_pkg::st_second:
          state_q <= decode_pkg::st_first;
      endcase
    end
  end

  // decoded record towards the execute datapath
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      dec_valid_q <= 1'b0;
      decoded_q <= '0;
      last_word_q <= decode_pkg::WORD_RST;
    end
    else
    begin
      dec_valid_q <= emit;
      if (emit)
        decoded_q <= dec_d;
      if (emit)
        last_word_q <= first_w;
    end
  end

  // apb decode; one wait state so read data comes from a flop
  wire logic access;
  wire logic wr_en;
  wire logic hit_ctrl;
  wire logic hit_bank;
  wire logic hit_status;
  wire logic hit_last;
  wire logic hit_orph;
  wire logic mapped;
  wire logic [31:0] rd_data;
  assign access = psel_in & penable_in;
  assign wr_en = access & pready_q & pwrite_in & mapped;
  assign hit_ctrl = paddr_in == decode_pkg::OFS_CTRL;
  assign hit_bank = paddr_in == decode_pkg::OFS_BANK;
  assign hit_status = paddr_in == decode_pkg::OFS_STATUS;
  assign hit_last = paddr_in == decode_pkg::OFS_LAST_WORD;
  assign hit_orph = paddr_in == decode_pkg::OFS_ORPHANS;
  assign mapped = hit_ctrl | hit_bank | hit_status | hit_last | hit_orph;
  assign rd_data = hit_ctrl ? {31'h0, enable_q} :
                   hit_bank ? {28'h0, bank_q} :
                   hit_status ? {27'h0, flags} :
                   hit_last ? {16'h0, last_word_q} :
                   hit_orph ? {16'h0, orphan_q} : 32'h0;

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~mapped;
      if (access & ~pready_q)
        prdata_q <= pwrite_in ? 32'h0 : rd_data;
    end
  end

  // writable control state; orphan count cleared by any write to its register
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_b_in)
    begin
      enable_q <= decode_pkg::CTRL_RST;
      bank_q <= decode_pkg::BANK_RST;
      orphan_q <= decode_pkg::ORPHAN_RST;
    end
    else
    begin
      if (wr_en && hit_ctrl && pstrb_in[0])
        enable_q <= pwdata_in[decode_pkg::CTRL_ENABLE_BIT];
      if (wr_en && hit_bank && pstrb_in[0])
        bank_q <= pwdata_in[3:0];
      // a new orphan in the clearing cycle still counts
      if (orphan)
        orphan_q <= (wr_en && hit_orph) ? 16'h0001 : orphan_q + 16'h0001;
      else if (wr_en && hit_orph)
        orphan_q <= decode_pkg::ORPHAN_RST;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < decode_pkg::FLAG_N; gi++)
    begin : g_flag
      status_flag_bit #(
        .RST_VAL(decode_pkg::FLAGS_RST[gi])
      ) u_flag (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .hw_we_in(flag_we_in[gi]),
        .hw_val_in(flag_val_in[gi]),
        .sw_we_in(wr_en & hit_status & pstrb_in[0]),
        .sw_val_in(pwdata_in[gi]),
        .flag_out(flags[gi])
      );
    end
  endgenerate

  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign dec_valid_out = dec_valid_q;
  assign decoded_out = decoded_q;
  assign status_flags_out = flags;

  // checks on the decoded record and the status flags
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  wire logic one_word;
  wire logic pair_done;
  assign one_word = emit & ~in_second;
  assign pair_done = emit & in_second & ~second_bad;

  a_dest_route: assert property (
    one_word && is_byte |=> decoded_out.write_file ==
      $past(fetch_word_in[9]) && decoded_out.write_working ==
      !$past(fetch_word_in[9]))
    else $error("byte result routing wrong");
  a_bank_pick: assert property (
    one_word && (is_byte || is_bit) && fetch_word_in[8] |=>
      decoded_out.file_addr[11:8] == $past(bank_q))
    else $error("banked address not from bank select");
  a_window_pick: assert property (
    one_word && (is_byte || is_bit) && !fetch_word_in[8] |=>
      decoded_out.file_addr[11:8] == ($past(fetch_word_in[7:0]) <
      ACCESS_SPLIT ? 4'h0 : 4'hf))
    else $error("access window address wrong");
  a_file_byte: assert property (
    one_word && (is_byte || is_bit) |=>
      decoded_out.file_addr[7:0] == $past(fetch_word_in[7:0]))
    else $error("file byte not from low byte");
  a_move_pair: assert property (
    pair_done && pend_fmt_q == decode_pkg::fmt_move |=> dec_valid_out &&
      decoded_out.src_addr == $past(pend_q[11:0]) &&
      decoded_out.dst_addr == $past(fetch_word_in[11:0]))
    else $error("file move addresses wrong");
  a_bit_index: assert property (
    one_word && is_bit |=> decoded_out.bit_index ==
      $past(fetch_word_in[11:9]))
    else $error("bit index wrong");
  a_literal_byte: assert property (
    one_word && is_lit |=> decoded_out.literal ==
      $past(fetch_word_in[7:0]))
    else $error("immediate wrong");
  a_jump_target: assert property (
    pair_done && pend_fmt_q != decode_pkg::fmt_move |=>
      decoded_out.target == {$past(fetch_word_in[11:0]),
      $past(pend_q[7:0])})
    else $error("jump target wrong");
  a_call_fast: assert property (
    pair_done && pend_fmt_q == decode_pkg::fmt_call |=>
      decoded_out.fast == $past(pend_q[8]))
    else $error("fast bit wrong");
  a_rel_offset: assert property (
    one_word && is_rel |=> decoded_out.offset ==
      $past(fetch_word_in[10:0]))
    else $error("relative offset wrong");
  a_cond_offset: assert property (
    one_word && is_cond |=> decoded_out.offset[7:0] ==
      $past(fetch_word_in[7:0]))
    else $error("conditional offset wrong");
  a_flag_update: assert property (
    flag_we_in != 5'h00 |=> ((status_flags_out ^ $past(flag_val_in)) &
      $past(flag_we_in)) == 5'h00)
    else $error("flag not updated from execute");
  a_orphan_nop: assert property (
    orphan |=> dec_valid_out && decoded_out.fmt == decode_pkg::fmt_nop)
    else $error("lone second word not a nop");
endmodule : instruction_format_decoder
`default_nettype wire

// File: bench/fetch_source.sv
// stand-in for the fetch path and execute flag updates
`timescale 1ns/1ps
`default_nettype none
module fetch_source (
  input wire logic core_clk_in,
  output logic fetch_valid_out,
  output logic [15:0] fetch_word_out,
  output logic [4:0] flag_we_out,
  output logic [4:0] flag_val_out
);
  // quiet at time zero so no word is offered during reset
  initial
  begin
    fetch_valid_out = 1'b0;
    fetch_word_out = 16'h0000;
    flag_we_out = 5'h00;
    flag_val_out = 5'h00;
  end

  // idle cycles flip the stale word so a decoder reading it shows up
  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge core_clk_in);
      fetch_valid_out <= 1'b0;
      fetch_word_out <= ~fetch_word_out;
    end
  endtask : idle

  // offers one word after an optional stall; the next call replaces it
  task automatic send(input logic [15:0] w, input int stall);
    idle(stall);
    @(posedge core_clk_in);
    fetch_valid_out <= 1'b1;
    fetch_word_out <= w;
  endtask : send

  // one-cycle flag update from the execute side
  task automatic flag(input logic [4:0] we, input logic [4:0] val);
    @(posedge core_clk_in);
    flag_we_out <= we;
    flag_val_out <= val;
    @(posedge core_clk_in);
    flag_we_out <= 5'h00;
    flag_val_out <= ~val;
  endtask : flag
endmodule : fetch_source
`default_nettype wire

// File: bench/tb.sv
// testbench: decoder against a reference model over fetch and apb
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [7:0] SPLIT = 8'h80;
  logic core_clk_in, rst_b_in, psel, penable, pwrite, pready, pslverr;
  logic fv, dv, err, pair;
  logic [11:0] paddr;
  logic [11:0] ofs [6];
  logic [31:0] pwdata, prdata, rd, r, s;
  logic [3:0] pstrb, bank_m;
  logic [15:0] fw, w1, w2;
  logic [4:0] fwe, fval, flags, flags_m;
  decode_pkg::decode_s dec, e, m;
  decode_pkg::decode_s exp_q[$];
  decode_pkg::decode_s msk_q[$];
  int failures, samples_checked, seed, orphans_m;

  initial
  begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  instruction_format_decoder #(.ACCESS_SPLIT(SPLIT)) u_dut (
    .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .paddr_in(paddr),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .fetch_valid_in(fv),
    .fetch_word_in(fw), .flag_we_in(fwe), .flag_val_in(fval),
    .dec_valid_out(dv), .decoded_out(dec), .status_flags_out(flags));

  fetch_source u_src (.core_clk_in(core_clk_in), .fetch_valid_out(fv),
    .fetch_word_out(fw), .flag_we_out(fwe), .flag_val_out(fval));

  task automatic end_of_test();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk_word(input logic [31:0] got, input logic [31:0] x,
                          input string what);
    samples_checked++;
    if (got !== x)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, x);
    end
  endtask : chk_word

  // only the fields that belong to the format are compared
  task automatic chk_dec(input decode_pkg::decode_s got,
                         input decode_pkg::decode_s x,
                         input decode_pkg::decode_s msk);
    samples_checked++;
    if (((got ^ x) & msk) !== '0)
    begin
      failures++;
      $display("mismatch at %0t: decode got %h exp %h", $time, got, x);
    end
  endtask : chk_dec

  // apb master: holds the request until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, input logic [3:0] st);
    int n;
    @(posedge core_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    pstrb <= st;
    @(posedge core_clk_in);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk_in);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      chk_word(32'h1, 32'h0, "no ready");
      end_of_test();
    end
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] x,
                       input logic xe);
    apb(1'b0, a, 32'h0, 4'hf);
    chk_word(rd, x, "read data");
    chk_word({31'h0, err}, {31'h0, xe}, "slave error");
  endtask : rdchk

  // reference decode; every field is computed, the mask picks the used ones
  task automatic expect_op(input logic [15:0] a1, input logic [15:0] a2);
    logic [3:0] hb;
    hb = (a1[7:0] < SPLIT) ? decode_pkg::ACCESS_LOW_BANK
                           : decode_pkg::ACCESS_HIGH_BANK;
    e = '0;
    m = '0;
    m.fmt = decode_pkg::fmt_e'(4'hf);
    pair = 1'b0;
    e.file_addr = {a1[8] ? bank_m : hb, a1[7:0]};
    e.bank_access = a1[8];
    e.bit_index = a1[11:9];
    e.write_file = a1[9];
    e.write_working = ~a1[9];
    e.literal = a1[7:0];
    e.src_addr = a1[11:0];
    e.dst_addr = a2[11:0];
    e.target = {a2[11:0], a1[7:0]};
    e.fast = a1[8];
    e.offset = (a1[15:12] == 4'hd) ? a1[10:0] : {{3{a1[7]}}, a1[7:0]};
    m.offset = '1;
    case (a1[15:12])
      4'h0: e.fmt = decode_pkg::fmt_literal;
      4'h2: e.fmt = decode_pkg::fmt_byte;
      4'hc: e.fmt = decode_pkg::fmt_move;
      4'hd: e.fmt = decode_pkg::fmt_rel_branch;
      4'hf: e.fmt = decode_pkg::fmt_nop;
      4'he: e.fmt = !a1[11] ? decode_pkg::fmt_cond_branch
        : (a1[10:8] == 3'b111) ? decode_pkg::fmt_jump : decode_pkg::fmt_call;
      default: e.fmt = decode_pkg::fmt_bit;
    endcase
    if (e.fmt != decode_pkg::fmt_rel_branch &&
        e.fmt != decode_pkg::fmt_cond_branch)
      m.offset = '0;
    m.literal = {8{e.fmt == decode_pkg::fmt_literal}};
    m.write_file = (e.fmt == decode_pkg::fmt_byte);
    m.write_working = (e.fmt == decode_pkg::fmt_byte);
    m.bank_access = (e.fmt inside {decode_pkg::fmt_byte, decode_pkg::fmt_bit});
    m.file_addr = {12{m.bank_access}};
    m.bit_index = {3{e.fmt == decode_pkg::fmt_bit}};
    m.src_addr = {12{e.fmt == decode_pkg::fmt_move}};
    m.dst_addr = m.src_addr;
    m.fast = (e.fmt == decode_pkg::fmt_call);
    pair = (e.fmt inside {decode_pkg::fmt_move, decode_pkg::fmt_jump,
                          decode_pkg::fmt_call});
    m.target = {20{pair && e.fmt != decode_pkg::fmt_move}};
    if (e.fmt == decode_pkg::fmt_nop)
      orphans_m++;
    // a broken pair leaves only a no-operation behind
    if (pair && a2[15:12] != decode_pkg::TAG_SECOND)
    begin
      e.fmt = decode_pkg::fmt_nop;
      m = '0;
      m.fmt = decode_pkg::fmt_e'(4'hf);
    end
    exp_q.push_back(e);
    msk_q.push_back(m);
  endtask : expect_op

  task automatic op(input logic [15:0] a1, input logic [15:0] a2,
                    input int stall);
    expect_op(a1, a2);
    u_src.send(a1, 0);
    if (pair)
      u_src.send(a2, stall);
  endtask : op

  task automatic drain();
    u_src.idle(2);
    for (int n = 0; n < 16 && exp_q.size() > 0; n++)
      @(posedge core_clk_in);
    chk_word(32'(exp_q.size()), 32'h0, "decodes missing");
    if (exp_q.size() > 0)
      end_of_test();
  endtask : drain

  // every decode pulse is matched against the oldest expectation
  always @(posedge core_clk_in)
  begin
    if (dv === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk_word(32'h1, 32'h0, "unexpected decode");
      else
        chk_dec(dec, exp_q.pop_front(), msk_q.pop_front());
    end
  end

  initial
  begin
    repeat (20000) @(posedge core_clk_in);
    chk_word(32'h1, 32'h0, "timeout");
    end_of_test();
  end

  initial
  begin
    seed = 32'hf63b;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {failures, samples_checked, orphans_m} = '0;
    bank_m = 4'h0;
    ofs = '{decode_pkg::OFS_CTRL, decode_pkg::OFS_BANK,
            decode_pkg::OFS_STATUS, decode_pkg::OFS_LAST_WORD,
            decode_pkg::OFS_ORPHANS, 12'h020};
    rst_b_in = 1'b0;
    repeat (4) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 6; i++)
      rdchk(ofs[i], {31'h0, i == 0}, i == 5);
    $display("test reset values done");
    r = $random(seed);
    apb(1'b1, decode_pkg::OFS_BANK, r, 4'hf);
    bank_m = r[3:0];
    apb(1'b1, decode_pkg::OFS_BANK, ~r, 4'h0);
    rdchk(decode_pkg::OFS_BANK, {28'h0, bank_m}, 1'b0);
    for (int i = 0; i < 60; i++)
    begin
      r = $random(seed);
      s = $random(seed);
      case (i % 10)
        0: w1 = {4'h2, 2'b01, r[9:0]};
        1: w1 = {4'h7 + {2'b00, r[13:12]}, r[11:0]};
        2: w1 = {8'h0e, r[7:0]};
        3, 9: w1 = {4'hc, r[11:0]};
        4: w1 = {8'hef, r[7:0]};
        5: w1 = {7'h76, r[8:0]};
        6: w1 = {5'h1a, r[10:0]};
        7: w1 = {5'h1c, r[10:0]};
        default: w1 = {4'hf, r[11:0]};
      endcase
      w2 = {(i % 10 == 9) ? 4'h0 : 4'hf, s[11:0]};
      op(w1, w2, int'(s[13:12]));
    end
    drain();
    rdchk(decode_pkg::OFS_ORPHANS, 32'(orphans_m), 1'b0);
    apb(1'b1, decode_pkg::OFS_ORPHANS, 32'h0, 4'hf);
    rdchk(decode_pkg::OFS_ORPHANS, 32'h0, 1'b0);
    $display("test formats done");
    // words offered while disabled must produce nothing
    apb(1'b1, decode_pkg::OFS_CTRL, 32'h0, 4'hf);
    u_src.send(16'h2401, 0);
    u_src.idle(3);
    apb(1'b1, decode_pkg::OFS_CTRL, 32'h1, 4'hf);
    op(16'h2701, 16'h0, 0);
    drain();
    $display("test enable done");
    flags_m = 5'h00;
    for (int i = 0; i < 5; i++)
    begin
      r = $random(seed);
      u_src.flag(5'(1 << i), r[4:0]);
      flags_m[i] = r[i];
      @(negedge core_clk_in);
      chk_word({27'h0, flags}, {27'h0, flags_m}, "flags");
    end
    rdchk(decode_pkg::OFS_STATUS, {27'h0, flags_m}, 1'b0);
    apb(1'b1, decode_pkg::OFS_STATUS, 32'h15, 4'hf);
    rdchk(decode_pkg::OFS_STATUS, 32'h15, 1'b0);
    $display("test flags done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
